// file: src/flash_otp_defs.svh
`ifndef FLASH_OTP_DEFS_SVH
`define FLASH_OTP_DEFS_SVH

// Register byte offsets on APB
`define OFF_PARAM_INDEX   12'h000
`define OFF_PARAM_WORD    12'h004
`define OFF_STATUS        12'h008
`define OFF_SECURITY      12'h00C
`define OFF_CONTROL       12'h010

// Status bit positions
`define ST_CMD_COMPLETE_FLAG           7
`define ST_ACCESS_ERROR_FLAG         5
`define ST_PROTECTION_VIOLATION_FLAG         4
`define ST_MG1            1
`define ST_MG0            0
`define STATUS_RESET      8'h80

// Command codes and parameter indices
`define CMD_PROGRAM       8'h06
`define CMD_READ_ONCE     8'h04
`define CMD_PROGRAM_ONCE  8'h07
`define IDX_CMD           3'h0
`define IDX_PHRASE        3'h1
`define IDX_DATA0         3'h2
`define IDX_LAST          3'h5

// One-time field: 8 phrases of 64 bits (64 bytes)
`define OTP_PHRASES       8
`define OTP_BASE          18'h040C0
`define OTP_TOP           18'h040FF
`define SEC_BYTE_ADDR     18'h3FF0F
`define PFLASH_LO         18'h20000

// Security byte fields
`define BACKDOOR_KEY_ENABLE_HI          7
`define BACKDOOR_KEY_ENABLE_LO          6
`define BACKDOOR_KEY_ENABLE_ON          2'h2
`define SEC_UNSECURE      2'h1
`define SEC_FORCED        2'h2
`define SEC_ALL_SET       8'hFF

// Array timing
`define PROG_TIME_NS      40
`define CLK_PERIOD_NS     8
`define PROG_CYCLES       (((`PROG_TIME_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))

`endif

// file: src/flash_otp_pkg.sv
package flash_otp_pkg;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_CHECK  = 3'b001,
		ST_WRITE  = 3'b010,
		ST_VERIFY = 3'b011,
		ST_DONE   = 3'b100
	} seq_state_t;
endpackage : flash_otp_pkg

// file: src/flash_otp_ctrl.sv
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "flash_otp_defs.svh"

// What this block does
// - Read-once reads only the 64-byte, 8-phrase one-time field.
// - Read-once code 0x04 at index 0, phrase at 1, words returned from index 2.
// - Security register reads fully; writes are ignored.
// - Security register loads from the configuration security byte at reset.
// - Double-bit fault while loading sets every security bit.
// - Backdoor key enabled only when bits 7-6 equal 10.
// - Bits 1-0 give security state; forced to 10 after backdoor unsecure.
// - Program sets access error if index is not 5 at launch.
// - Program sets access error on invalid or misaligned address.
// - Unavailable command in current mode sets access error.
// - Program into a protected area sets protection violation.
// - Verify error sets first flag; non-correctable sets second too.
// - Program-once: code 0x07, phrase at 1, four data words at 2..5.
// - Program-once writes only the one-time field; it cannot be erased.
// - Program-once checks erased, then programs, then verifies by read back.
// - Clearing complete flag launches; it stays clear until done.
// - Programming an already programmed phrase is refused.
// - Reads of program flash return invalid data during program-once.
// - One-time field spans 0x0_40C0 to 0x0_40FF.
module flash_otp_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  sec_byte_in,
	input  wire logic        sec_byte_dbe,
	input  wire logic        sec_load_done,
	input  wire logic        backdoor_ok,
	input  wire logic [1:0]  verify_fault,
	output logic             pflash_read_invalid,
	output logic             backdoor_key_enable_active
);

	////////////////////////////////////////////////////////////////////////
	logic        sel_q, dbe_s1_q, dbe_q, done_s1_q, done_q, bd_s1_q, bd_q;
	logic [7:0]  byte_s1_q, byte_q;
	logic [1:0]  vf_s1_q, vf_q;
	logic [2:0]  param_index_q;
	logic [15:0] param_q [0:5];
	logic [7:0]  status_q;
	logic [7:0]  security_config_q;
	logic        sec_loaded_q;
	logic [63:0] otp_q [0:`OTP_PHRASES-1];
	logic [`OTP_PHRASES-1:0] otp_used_q;
	logic [2:0]  phrase_q;
	logic [3:0]  timer_q;
	logic [7:0]  protect_q;
	logic        ro_mode_q;
	flash_otp_pkg::seq_state_t state_q;

	logic        acc, wr_en, rd_en;
	logic        launch;
	assign acc   = psel & penable;
	assign wr_en = acc & pwrite;
	assign rd_en = acc & ~pwrite;

	function automatic logic addr_bad(input logic [17:0] a);
		addr_bad = (a < `PFLASH_LO) | (a[2:0] != 3'h0);
	endfunction : addr_bad

	function automatic logic addr_protected(input logic [17:0] a, input logic [7:0] p);
		addr_protected = (p != 8'h00) & (a[17:10] >= (8'hFF - p));
	endfunction : addr_protected

	////////////////////////////////////////////////////////////////////////
	// Pin inputs synchronised; first stage read only by second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dbe_s1_q  <= 1'b0;
			dbe_q     <= 1'b0;
			done_s1_q <= 1'b0;
			done_q    <= 1'b0;
			bd_s1_q   <= 1'b0;
			bd_q      <= 1'b0;
			byte_s1_q <= 8'h00;
			byte_q    <= 8'h00;
			vf_s1_q   <= 2'h0;
			vf_q      <= 2'h0;
		end else begin
			dbe_s1_q  <= sec_byte_dbe;
			dbe_q     <= dbe_s1_q;
			done_s1_q <= sec_load_done;
			done_q    <= done_s1_q;
			bd_s1_q   <= backdoor_ok;
			bd_q      <= bd_s1_q;
			byte_s1_q <= sec_byte_in;
			byte_q    <= byte_s1_q;
			vf_s1_q   <= verify_fault;
			vf_q      <= vf_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Security register: loaded once after reset, never written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			security_config_q <= `SEC_ALL_SET;
			sec_loaded_q      <= 1'b0;
		end else if (!sec_loaded_q && done_q) begin
			sec_loaded_q      <= 1'b1;
			security_config_q <= dbe_q ? `SEC_ALL_SET : byte_q;
		end else if (sec_loaded_q && bd_q
			&& security_config_q[`BACKDOOR_KEY_ENABLE_HI:`BACKDOOR_KEY_ENABLE_LO] == `BACKDOOR_KEY_ENABLE_ON) begin
			security_config_q[1:0] <= `SEC_FORCED;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			backdoor_key_enable_active <= 1'b0;
		end else begin
			backdoor_key_enable_active <= security_config_q[`BACKDOOR_KEY_ENABLE_HI:`BACKDOOR_KEY_ENABLE_LO] == `BACKDOOR_KEY_ENABLE_ON;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Launch: write 1 to complete flag while idle clears it
	assign launch = wr_en && sel_q && paddr == `OFF_STATUS && pwdata[`ST_CMD_COMPLETE_FLAG]
		&& state_q == flash_otp_pkg::ST_IDLE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			param_index_q <= 3'h0;
			protect_q     <= 8'h00;
			ro_mode_q     <= 1'b0;
			for (int i = 0; i < 6; i++) begin
				param_q[i] <= 16'h0000;
			end
		end else begin
			if (wr_en && sel_q && state_q == flash_otp_pkg::ST_IDLE) begin
				if (paddr == `OFF_PARAM_INDEX) begin
					param_index_q <= pwdata[2:0];
				end
				if (paddr == `OFF_PARAM_WORD && param_index_q <= `IDX_LAST) begin
					param_q[param_index_q] <= pwdata[15:0];
				end
				if (paddr == `OFF_CONTROL) begin
					protect_q <= pwdata[7:0];
					ro_mode_q <= pwdata[8];
				end
			end
			if (state_q == flash_otp_pkg::ST_DONE && param_q[0][15:8] == `CMD_READ_ONCE) begin
				for (int w = 0; w < 4; w++) begin
					param_q[w+2] <= otp_q[phrase_q][w*16 +: 16];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	logic [7:0]  cmd;
	logic [17:0] gaddr;
	logic        acc_err;
	logic        erased;
	assign cmd   = param_q[0][15:8];
	assign gaddr = {param_q[0][1:0], param_q[1]};
	assign erased = ~otp_used_q[param_q[1][2:0]];

	always_comb begin
		acc_err = 1'b0;
		unique case (cmd)
			`CMD_PROGRAM: begin
				acc_err = (param_index_q != `IDX_LAST) | addr_bad(gaddr) | ro_mode_q;
			end
			`CMD_READ_ONCE: begin
				acc_err = (param_index_q != `IDX_PHRASE) | (param_q[1] > 16'h0007);
			end
			`CMD_PROGRAM_ONCE: begin
				acc_err = (param_index_q != `IDX_LAST) | (param_q[1] > 16'h0007) | ro_mode_q;
			end
			default: begin
				acc_err = 1'b1;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= flash_otp_pkg::ST_IDLE;
			status_q   <= `STATUS_RESET;
			phrase_q   <= 3'h0;
			timer_q    <= 4'h0;
			otp_used_q <= '0;
			for (int p = 0; p < `OTP_PHRASES; p++) begin
				otp_q[p] <= 64'hFFFF_FFFF_FFFF_FFFF;
			end
		end else begin
			if (wr_en && sel_q && paddr == `OFF_STATUS) begin
				if (pwdata[`ST_ACCESS_ERROR_FLAG]) status_q[`ST_ACCESS_ERROR_FLAG] <= 1'b0;
				if (pwdata[`ST_PROTECTION_VIOLATION_FLAG]) status_q[`ST_PROTECTION_VIOLATION_FLAG] <= 1'b0;
			end
			unique case (state_q)
				flash_otp_pkg::ST_IDLE: begin
					if (launch) begin
						status_q[`ST_CMD_COMPLETE_FLAG] <= 1'b0;
						status_q[`ST_MG1]  <= 1'b0;
						status_q[`ST_MG0]  <= 1'b0;
						phrase_q <= param_q[1][2:0];
						timer_q  <= 4'(`PROG_CYCLES);
						if (acc_err) begin
							status_q[`ST_ACCESS_ERROR_FLAG] <= 1'b1;
							state_q <= flash_otp_pkg::ST_DONE;
						end else if (cmd == `CMD_PROGRAM && addr_protected(gaddr, protect_q)) begin
							status_q[`ST_PROTECTION_VIOLATION_FLAG] <= 1'b1;
							state_q <= flash_otp_pkg::ST_DONE;
						end else if (cmd == `CMD_PROGRAM_ONCE) begin
							state_q <= flash_otp_pkg::ST_CHECK;
						end else begin
							state_q <= flash_otp_pkg::ST_DONE;
						end
					end
				end
				flash_otp_pkg::ST_CHECK: begin
					if (erased) begin
						state_q <= flash_otp_pkg::ST_WRITE;
					end else begin
						status_q[`ST_ACCESS_ERROR_FLAG] <= 1'b1;
						state_q <= flash_otp_pkg::ST_DONE;
					end
				end
				flash_otp_pkg::ST_WRITE: begin
					if (timer_q == 4'h0) begin
						otp_q[phrase_q] <= {param_q[5], param_q[4], param_q[3], param_q[2]};
						otp_used_q[phrase_q] <= 1'b1;
						state_q <= flash_otp_pkg::ST_VERIFY;
					end else begin
						timer_q <= timer_q - 4'h1;
					end
				end
				flash_otp_pkg::ST_VERIFY: begin
					if (otp_q[phrase_q] != {param_q[5], param_q[4], param_q[3], param_q[2]}
						|| vf_q[1]) begin
						status_q[`ST_MG1] <= 1'b1;
					end
					if (vf_q[0]) begin
						status_q[`ST_MG1] <= 1'b1;
						status_q[`ST_MG0] <= 1'b1;
					end
					state_q <= flash_otp_pkg::ST_DONE;
				end
				flash_otp_pkg::ST_DONE: begin
					status_q[`ST_CMD_COMPLETE_FLAG] <= 1'b1;
					state_q <= flash_otp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pflash_read_invalid <= 1'b0;
		end else begin
			pflash_read_invalid <= (state_q == flash_otp_pkg::ST_CHECK)
				|| (state_q == flash_otp_pkg::ST_WRITE)
				|| (state_q == flash_otp_pkg::ST_VERIFY);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB: no wait states, answer registered from the setup cycle
	logic mapped;
	assign mapped = paddr == `OFF_PARAM_INDEX || paddr == `OFF_PARAM_WORD
		|| paddr == `OFF_STATUS || paddr == `OFF_SECURITY || paddr == `OFF_CONTROL;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q   <= 1'b0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			sel_q   <= psel & ~penable;
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					`OFF_PARAM_INDEX: prdata <= {29'h0, param_index_q};
					`OFF_PARAM_WORD: prdata <= (param_index_q <= `IDX_LAST)
						? {16'h0, param_q[param_index_q]} : 32'h0;
					`OFF_STATUS:   prdata <= {24'h0, status_q};
					`OFF_SECURITY: prdata <= {24'h0, security_config_q};
					`OFF_CONTROL:  prdata <= {23'h0, ro_mode_q, protect_q};
					default:       prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	sequence s_launch;
		launch && !acc_err && cmd == `CMD_PROGRAM_ONCE;
	endsequence

	a_cmd_complete_flag_clear_launch: assert property (@(posedge pclk) disable iff (!presetn)
		launch |=> !status_q[`ST_CMD_COMPLETE_FLAG]) else $error("complete flag not cleared");

	a_po_sequence: assert property (@(posedge pclk) disable iff (!presetn)
		s_launch |=> state_q == flash_otp_pkg::ST_CHECK) else $error("no erase check");

	a_po_invalid_read: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == flash_otp_pkg::ST_WRITE |=> pflash_read_invalid)
		else $error("reads not invalid");

	a_reprogram_refused: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == flash_otp_pkg::ST_CHECK && !erased |=> status_q[`ST_ACCESS_ERROR_FLAG])
		else $error("reprogram not refused");

	a_prog_index: assert property (@(posedge pclk) disable iff (!presetn)
		launch && cmd == `CMD_PROGRAM && param_index_q != `IDX_LAST |=> status_q[`ST_ACCESS_ERROR_FLAG])
		else $error("bad index not flagged");

	a_misaligned: assert property (@(posedge pclk) disable iff (!presetn)
		launch && cmd == `CMD_PROGRAM && gaddr[2:0] != 3'h0 |=> status_q[`ST_ACCESS_ERROR_FLAG])
		else $error("misaligned not flagged");

	a_bad_cmd: assert property (@(posedge pclk) disable iff (!presetn)
		launch && acc_err |=> ##1 status_q[`ST_CMD_COMPLETE_FLAG] && status_q[`ST_ACCESS_ERROR_FLAG])
		else $error("unknown command not flagged");

	a_sec_dbe: assert property (@(posedge pclk) disable iff (!presetn)
		!sec_loaded_q && done_q && dbe_q |=> security_config_q == `SEC_ALL_SET)
		else $error("security not all set on fault");

	a_sec_stable: assert property (@(posedge pclk) disable iff (!presetn)
		sec_loaded_q && !bd_q |=> $stable(security_config_q))
		else $error("security register changed");

	a_verify_fatal: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == flash_otp_pkg::ST_VERIFY && vf_q[0] |=> status_q[`ST_MG1] && status_q[`ST_MG0])
		else $error("verify flags wrong");

endmodule : flash_otp_ctrl

// file: bench/flash_security_otp_commands_tb.sv
`timescale 1ns/10ps
`include "flash_otp_defs.svh"
module flash_security_otp_commands_tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  sec_byte_in = 8'hBD;
	logic        sec_byte_dbe = 1'b0;
	logic        sec_load_done = 1'b0;
	logic        backdoor_ok = 1'b0;
	logic [1:0]  verify_fault = 2'h0;
	logic        pflash_read_invalid;
	logic        backdoor_key_enable_active;
	logic [31:0] rd;
	logic        err;
	logic        inv_seen;
	logic        clr_seen;
	int          n_errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	always #4 pclk = ~pclk;

	flash_otp_ctrl u_flash_otp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sec_byte_in(sec_byte_in),
		.sec_byte_dbe(sec_byte_dbe), .sec_load_done(sec_load_done),
		.backdoor_ok(backdoor_ok), .verify_fault(verify_fault),
		.pflash_read_invalid(pflash_read_invalid), .backdoor_key_enable_active(backdoor_key_enable_active));

	////////////////////////////////////////////////////////////////////////////////
	task summarize;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	// Runaway guard: whole run needs under a thousand cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 50000) begin
			n_errors++;
			summarize();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task setp(input logic [2:0] idx, input logic [15:0] v);
		apb(1'b1, `OFF_PARAM_INDEX, {29'h0, idx});
		apb(1'b1, `OFF_PARAM_WORD, {16'h0, v});
	endtask : setp

	// Launch, poll for completion, compare status, then clear sticky errors
	task run(input logic [7:0] exp, input logic lng);
		int i;
		apb(1'b1, `OFF_STATUS, 32'h0000_0080);
		inv_seen = 1'b0;
		clr_seen = 1'b0;
		for (i = 0; i < 100; i++) begin
			if (pflash_read_invalid === 1'b1)
				inv_seen = 1'b1;
			apb(1'b0, `OFF_STATUS, 32'h0);
			if (rd[7] === 1'b0)
				clr_seen = 1'b1;
			if (rd[7] === 1'b1)
				break;
		end
		chk({24'h0, rd[7:0]}, {24'h0, exp});
		if (lng) begin
			chk(32'(inv_seen), 32'h1);
			chk(32'(clr_seen), 32'h1);
		end
		apb(1'b1, `OFF_STATUS, 32'h0000_0030);
	endtask : run

	task otp(input logic [7:0] code, input logic [15:0] ph, input logic [15:0] b);
		int i;
		setp(`IDX_CMD, {code, 8'h00});
		setp(`IDX_PHRASE, ph);
		if (code == `CMD_PROGRAM_ONCE)
			for (i = 2; i <= 5; i++)
				setp(3'(i), b + 16'(i));
	endtask : otp

	task words(input logic [15:0] b);
		int i;
		for (i = 2; i <= 5; i++) begin
			apb(1'b1, `OFF_PARAM_INDEX, 32'(i));
			apb(1'b0, `OFF_PARAM_WORD, 32'h0);
			chk({16'h0, rd[15:0]}, {16'h0, b + 16'(i)});
		end
	endtask : words

	task pgm(input logic [17:0] a, input int last, input logic [7:0] exp);
		int i;
		setp(`IDX_CMD, {`CMD_PROGRAM, 6'h0, a[17:16]});
		setp(`IDX_PHRASE, a[15:0]);
		for (i = 2; i <= last; i++)
			setp(3'(i), 16'h1234);
		run(exp, 1'b0);
	endtask : pgm

	task do_reset(input logic [7:0] sb, input logic dbe);
		presetn <= 1'b0;
		sec_load_done <= 1'b0;
		sec_byte_in <= sb;
		sec_byte_dbe <= dbe;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		sec_load_done <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask : do_reset

	////////////////////////////////////////////////////////////////////////////////
	task t_reset_load;
		apb(1'b0, `OFF_STATUS, 32'h0);
		chk({24'h0, rd[7:0]}, 32'h0000_0080);
		apb(1'b0, `OFF_SECURITY, 32'h0);
		chk(rd, 32'h0000_00FF);
		sec_load_done <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1'b1, `OFF_SECURITY, 32'h0000_0000);
		apb(1'b0, `OFF_SECURITY, 32'h0);
		chk(rd, 32'h0000_00BD);
		apb(1'b0, 12'h020, 32'h0);
		chk({rd[30:0], err}, 32'h0000_0001);
	endtask : t_reset_load

	task t_backdoor_key_enable;
		int k;
		for (k = 0; k < 4; k++) begin
			do_reset({2'(k), 6'h3D}, 1'b0);
			apb(1'b0, `OFF_SECURITY, 32'h0);
			chk(rd, {24'h0, 2'(k), 6'h3D});
			chk(32'(backdoor_key_enable_active), 32'(k == 2));
		end
	endtask : t_backdoor_key_enable

	task t_sec_force;
		do_reset(8'hBD, 1'b1);
		apb(1'b0, `OFF_SECURITY, 32'h0);
		chk(rd, 32'h0000_00FF);
		chk(32'(backdoor_key_enable_active), 32'h0);
		do_reset(8'h7D, 1'b0);
		backdoor_ok <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1'b0, `OFF_SECURITY, 32'h0);
		chk(rd, 32'h0000_007D);
		backdoor_ok <= 1'b0;
		do_reset(8'hBD, 1'b0);
		backdoor_ok <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1'b0, `OFF_SECURITY, 32'h0);
		chk(rd, 32'h0000_00BE);
		backdoor_ok <= 1'b0;
	endtask : t_sec_force

	task t_otp;
		// Bench issues every command from outside the flash array
		otp(`CMD_PROGRAM_ONCE, 16'h0003, 16'hA000);
		run(8'h80, 1'b1);
		otp(`CMD_READ_ONCE, 16'h0003, 16'h0);
		run(8'h80, 1'b0);
		words(16'hA000);
		otp(`CMD_PROGRAM_ONCE, 16'h0003, 16'h5000);
		run(8'hA0, 1'b0);
		otp(`CMD_READ_ONCE, 16'h0003, 16'h0);
		run(8'h80, 1'b0);
		words(16'hA000);
		otp(`CMD_READ_ONCE, 16'h0008, 16'h0);
		run(8'hA0, 1'b0);
		verify_fault <= 2'h3;
		otp(`CMD_PROGRAM_ONCE, 16'h0005, 16'hB000);
		run(8'h83, 1'b1);
		verify_fault <= 2'h2;
		otp(`CMD_PROGRAM_ONCE, 16'h0006, 16'hC000);
		run(8'h82, 1'b1);
		verify_fault <= 2'h0;
	endtask : t_otp

	task t_prog_err;
		pgm(18'h20000, 5, 8'h80);
		pgm(18'h20000, 1, 8'hA0);
		pgm(18'h20003, 5, 8'hA0);
		pgm(18'h01000, 5, 8'hA0);
		apb(1'b1, `OFF_CONTROL, 32'h0000_0001);
		pgm(18'h3FF00, 5, 8'h90);
		apb(1'b1, `OFF_CONTROL, 32'h0000_0100);
		pgm(18'h20000, 5, 8'hA0);
		otp(`CMD_PROGRAM_ONCE, 16'h0000, 16'hD000);
		run(8'hA0, 1'b0);
		apb(1'b1, `OFF_CONTROL, 32'h0000_0000);
	endtask : t_prog_err

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_load();
		t_otp();
		t_prog_err();
		t_backdoor_key_enable();
		t_sec_force();
		summarize();
	end
endmodule : flash_security_otp_commands_tb
